// ### pkg/ispp_pkg.sv
// ispp_pkg: constants and types shared by the serial programming port files.
// assumes a 40 MHz core clock; link timing is set by the external programmer.
package ispp_pkg;

  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FIFO_AW     = 4;
  localparam int unsigned BIT_CNT_W   = 3;
  localparam int unsigned HOLD_W      = 19;

  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [2:0]  BIT_FIRST   = 3'h0;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  POLL_MSB    = 8'h80;
  localparam logic [7:0]  POLL_ERASE  = 8'h7f;

  // opcode of the programming-enable command; plain default
  localparam logic [7:0]  PROG_EN_OP  = 8'h00;

  localparam real         CLK_PERIOD_NS = 25.0;
  localparam real         T_WR_MS       = 2.5;
  localparam real         T_AWR_MS      = 5.0;
  localparam real         T_ERS_MS      = 7.5;
  localparam int unsigned WR_CYC  = int'($ceil(T_WR_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned AWR_CYC = int'($ceil(T_AWR_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned ERS_CYC = int'($ceil(T_ERS_MS * 1.0e6 / CLK_PERIOD_NS));

  typedef enum logic [1:0] {
    ISPP_TX_IDLE = 2'b01,
    ISPP_TX_WAIT = 2'b10
  } ispp_tx_state_t;

endpackage : ispp_pkg

// ### hw/ispp_mem.sv
// ispp_mem: small single-write, single-read memory with registered read data.
// assumes one clock; a read of the address written in the same cycle gives old data.
`timescale 1ns/100ps
module ispp_mem #(
  parameter int unsigned W  = 8,
  parameter int unsigned AW = 4
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data_r
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data_r <= mem[rd_addr];
  end

endmodule : ispp_mem

// ### hw/ispp_fifo.sv
// ispp_fifo: valid/ready fifo over ispp_mem; all outputs registered.
// assumes one clock and an active-low asynchronous reset already synchronised.
`timescale 1ns/100ps
module ispp_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready_r,
  // drain side
  output logic              out_valid_r,
  output logic      [W-1:0] out_data_r,
  input  wire logic         out_ready
);

  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  logic [AW:0]   vis_r;
  logic [AW:0]   vis_nxt;
  logic          push_d_r;
  logic          push;
  logic          pop;
  logic [AW-1:0] rd_addr;

  assign push      = in_valid && in_ready_r;
  assign pop       = out_valid_r && out_ready;
  assign rd_addr   = rd_ptr_r + AW'(pop);
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  // entries become visible one cycle late, after the memory has taken them
  assign vis_nxt   = vis_r + (AW+1)'(push_d_r) - (AW+1)'(pop);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      vis_r       <= '0;
      push_d_r    <= 1'b0;
      in_ready_r  <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      wr_ptr_r    <= wr_ptr_r + AW'(push);
      rd_ptr_r    <= rd_addr;
      count_r     <= count_nxt;
      vis_r       <= vis_nxt;
      push_d_r    <= push;
      in_ready_r  <= count_nxt != (AW+1)'(DEPTH);
      out_valid_r <= vis_nxt != '0;
    end
  end

  ispp_mem #(
    .W  (W),
    .AW (AW)
  ) u_mem (
    .clk       (clk),
    .wr_en     (push),
    .wr_addr   (wr_ptr_r),
    .wr_data   (in_data),
    .rd_addr   (rd_addr),
    .rd_data_r (out_data_r)
  );

endmodule : ispp_fifo

// ### hw/ispp_port.sv
// ispp_port: slave-only serial programming port; link logic on the serial clock,
// command logic on core_clk. assumes the programmer is the only master on the link.
//
// How it works
// - the programmer masters the link and clocks it; this end only answers as slave.
// - bits come in on mosi and go out on miso.
// - eight clocks move one byte in and one byte out together.
// - every byte travels most significant bit first, order fixed.
// - mode 0: clock idles low, sample on rise, change on fall.
// - first command after entering programming mode must be programming enable.
// - while busy, polled last byte returns inverted top bit; 7fh during erase.
`timescale 1ns/100ps
module ispp_port #(
  parameter int unsigned WR_CYC  = ispp_pkg::WR_CYC,
  parameter int unsigned AWR_CYC = ispp_pkg::AWR_CYC,
  parameter int unsigned ERS_CYC = ispp_pkg::ERS_CYC
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // serial link
  input  wire logic       spi_sck,
  input  wire logic       spi_ss_b,
  input  wire logic       spi_mosi,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_b,
  // received bytes
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  // bytes to send
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_poll,
  output logic            tx_ready,
  // programming control
  input  wire logic       isp_mode,
  input  wire logic       prog_busy,
  input  wire logic       erase_busy,
  input  wire logic       cyc_wr,
  input  wire logic       cyc_awr,
  input  wire logic       cyc_ers,
  // status
  output logic            prog_enabled,
  output logic            rx_overrun,
  output logic            early_cmd
);

  // reset release
  logic rst_s1_r;
  logic rst_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_r   <= 1'b1;
      rst_sync_b <= rst_s1_r;
    end
  end

  // ---------------- link domain, spi_sck ----------------
  logic [2:0] bit_cnt_r;
  logic [6:0] rsh_r;
  logic [7:0] lrx_byte_r;
  logic       lrx_tgl_r;
  logic       ltx_s1_r;
  logic       ltx_s2_r;
  logic       lack_r;
  logic [7:0] pend_r;
  logic [6:0] tsh_r;
  logic       miso_r;
  logic       oe_b_r;

  // core-domain words read by the link
  logic [7:0] tx_word_r;
  logic       tx_tgl_r;

  // frame state dies with slave select; nothing waits for a clock edge
  always_ff @(posedge spi_sck or posedge spi_ss_b) begin
    if (spi_ss_b) begin
      bit_cnt_r <= ispp_pkg::BIT_FIRST;
      rsh_r     <= '0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rsh_r     <= {rsh_r[5:0], spi_mosi};
    end
  end

  // byte hand-off survives frame ends so the toggle never glitches
  always_ff @(posedge spi_sck or negedge rst_b) begin
    if (!rst_b) begin
      lrx_byte_r <= ispp_pkg::BYTE_RST;
      lrx_tgl_r  <= 1'b0;
    end else if (!spi_ss_b && bit_cnt_r == ispp_pkg::BIT_LAST) begin
      lrx_byte_r <= {rsh_r, spi_mosi};
      lrx_tgl_r  <= ~lrx_tgl_r;
    end
  end

  // tx word handshake, link side
  always_ff @(posedge spi_sck or negedge rst_b) begin
    if (!rst_b) begin
      ltx_s1_r <= 1'b0;
      ltx_s2_r <= 1'b0;
      lack_r   <= 1'b0;
      pend_r   <= ispp_pkg::BYTE_RST;
    end else begin
      ltx_s1_r <= tx_tgl_r;
      ltx_s2_r <= ltx_s1_r;
      if (ltx_s2_r != lack_r) begin
        pend_r <= tx_word_r;
        lack_r <= ltx_s2_r;
      end
    end
  end

  // outgoing bits change on the falling edge; a fresh byte loads at each boundary
  always_ff @(negedge spi_sck or posedge spi_ss_b) begin
    if (spi_ss_b) begin
      tsh_r  <= '0;
      miso_r <= 1'b0;
      oe_b_r <= 1'b1;
    end else begin
      oe_b_r <= 1'b0;
      if (bit_cnt_r == ispp_pkg::BIT_FIRST) begin
        miso_r <= pend_r[7];
        tsh_r  <= pend_r[6:0];
      end else begin
        miso_r <= tsh_r[6];
        tsh_r  <= {tsh_r[5:0], 1'b0};
      end
    end
  end

  assign spi_miso_o    = miso_r;
  assign spi_miso_oe_b = oe_b_r;

  // ---------------- core domain ----------------
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_s3_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic new_byte;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rx_s1_r  <= 1'b0;
      rx_s2_r  <= 1'b0;
      rx_s3_r  <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      rx_s1_r  <= lrx_tgl_r;
      rx_s2_r  <= rx_s1_r;
      rx_s3_r  <= rx_s2_r;
      ack_s1_r <= lack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  assign new_byte = rx_s2_r ^ rx_s3_r;

  // enable gate: the first byte of a session must be the enable opcode
  logic first_done_r;
  logic enabled_r;
  logic accept;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      first_done_r <= 1'b0;
      enabled_r    <= 1'b0;
    end else if (!isp_mode) begin
      first_done_r <= 1'b0;
      enabled_r    <= 1'b0;
    end else if (new_byte && !first_done_r) begin
      first_done_r <= 1'b1;
      enabled_r    <= lrx_byte_r == ispp_pkg::PROG_EN_OP;
    end
  end

  assign accept = new_byte && enabled_r;

  // one-byte holding stage in front of the fifo; stalls when the fifo is full
  logic [7:0] hold_byte_r;
  logic       hold_v_r;
  logic       fifo_ready;
  logic       overrun_r;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hold_byte_r <= ispp_pkg::BYTE_RST;
      hold_v_r    <= 1'b0;
    end else if (accept && !(hold_v_r && !fifo_ready)) begin
      hold_byte_r <= lrx_byte_r;
      hold_v_r    <= 1'b1;
    end else if (fifo_ready) begin
      hold_v_r    <= 1'b0;
    end
  end

  // the master cannot be stalled, so a byte lost to a full fifo is only flagged
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      overrun_r <= 1'b0;
    end else if (accept && hold_v_r && !fifo_ready) begin
      overrun_r <= 1'b1;
    end else if (!isp_mode) begin
      overrun_r <= 1'b0;
    end
  end

  ispp_fifo #(
    .W     (ispp_pkg::BYTE_W),
    .DEPTH (ispp_pkg::FIFO_DEPTH),
    .AW    (ispp_pkg::FIFO_AW)
  ) u_rx_fifo (
    .clk         (core_clk),
    .rst_b       (rst_sync_b),
    .in_valid    (hold_v_r),
    .in_data     (hold_byte_r),
    .in_ready_r  (fifo_ready),
    .out_valid_r (rx_valid),
    .out_data_r  (rx_data),
    .out_ready   (rx_ready)
  );

  // hold-off timer after a write or erase starts; bytes inside it are flagged
  logic [ispp_pkg::HOLD_W-1:0] hold_cnt_r;
  logic                        early_r;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hold_cnt_r <= '0;
    end else if (cyc_ers) begin
      hold_cnt_r <= ispp_pkg::HOLD_W'(ERS_CYC);
    end else if (cyc_awr) begin
      hold_cnt_r <= ispp_pkg::HOLD_W'(AWR_CYC);
    end else if (cyc_wr) begin
      hold_cnt_r <= ispp_pkg::HOLD_W'(WR_CYC);
    end else if (hold_cnt_r != '0) begin
      hold_cnt_r <= hold_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      early_r <= 1'b0;
    end else if (new_byte && hold_cnt_r != '0) begin
      early_r <= 1'b1;
    end else if (!isp_mode) begin
      early_r <= 1'b0;
    end
  end

  // tx word handshake, core side
  ispp_pkg::ispp_tx_state_t tx_st_r;
  logic                     tx_ready_r;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tx_st_r    <= ispp_pkg::ISPP_TX_IDLE;
      tx_ready_r <= 1'b0;
      tx_tgl_r   <= 1'b0;
      tx_word_r  <= ispp_pkg::BYTE_RST;
    end else begin
      case (tx_st_r)
        ispp_pkg::ISPP_TX_IDLE: begin
          tx_ready_r <= 1'b1;
          if (tx_valid && tx_ready_r) begin
            tx_ready_r <= 1'b0;
            tx_tgl_r   <= ~tx_tgl_r;
            tx_st_r    <= ispp_pkg::ISPP_TX_WAIT;
            if (tx_poll && erase_busy) begin
              tx_word_r <= ispp_pkg::POLL_ERASE;
            end else if (tx_poll && prog_busy) begin
              tx_word_r <= tx_data ^ ispp_pkg::POLL_MSB;
            end else begin
              tx_word_r <= tx_data;
            end
          end
        end
        ispp_pkg::ISPP_TX_WAIT: begin
          if (ack_s2_r == tx_tgl_r) begin
            tx_st_r    <= ispp_pkg::ISPP_TX_IDLE;
            tx_ready_r <= 1'b1;
          end
        end
        default: begin
          tx_st_r    <= ispp_pkg::ISPP_TX_IDLE;
          tx_ready_r <= 1'b0;
        end
      endcase
    end
  end

  assign tx_ready     = tx_ready_r;
  assign prog_enabled = enabled_r;
  assign rx_overrun   = overrun_r;
  assign early_cmd    = early_r;

endmodule : ispp_port

// ### dv/ispp_port_props.sv
// ispp_port_props: port-level checks of the serial programming port.
// assumes it is bound to ispp_port and sees only that module's ports.
`timescale 1ns/100ps
module ispp_port_props (
  // clocks and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  // serial link
  input wire logic       spi_sck,
  input wire logic       spi_ss_b,
  input wire logic       spi_miso_o,
  input wire logic       spi_miso_oe_b,
  // user side
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       isp_mode,
  input wire logic       prog_enabled
);
  logic [3:0] rise_n;
  logic       miso_rise_r;
  // rises in the current frame; deselect clears it without a clock
  always_ff @(posedge spi_sck or posedge spi_ss_b) begin
    if (spi_ss_b) rise_n <= 4'h0;
    else if (rise_n != 4'hf) rise_n <= rise_n + 4'h1;
  end
  always_ff @(posedge spi_sck) begin
    miso_rise_r <= spi_miso_o;
  end
  AST_OE_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    spi_ss_b |-> spi_miso_oe_b) else $error("miso driven while deselected");
  AST_MISO_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    spi_ss_b |-> !spi_miso_o) else $error("miso not cleared while deselected");
  AST_OE_IN_FRAME: assert property (@(posedge spi_sck) disable iff (!rst_b || spi_ss_b)
    rise_n != 4'h0 |-> !spi_miso_oe_b) else $error("miso not driven in frame");
  AST_MISO_HOLD_HIGH: assert property (@(negedge spi_sck) disable iff (!rst_b || spi_ss_b)
    rise_n != 4'h0 |-> spi_miso_o == miso_rise_r) else $error("miso moved while sck high");
  AST_RX_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx byte lost");
  AST_TX_ONE_WORD: assert property (@(posedge core_clk) disable iff (!rst_b)
    tx_valid && tx_ready |=> !tx_ready) else $error("tx ready after accept");
  AST_MODE_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
    !isp_mode ##1 !isp_mode |-> !prog_enabled) else $error("enabled outside mode");
  AST_RX_AFTER_EN: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(rx_valid) |-> prog_enabled) else $error("byte before enable");
endmodule : ispp_port_props

bind ispp_port ispp_port_props u_props (.core_clk(core_clk), .rst_b(rst_b),
  .spi_sck(spi_sck), .spi_ss_b(spi_ss_b), .spi_miso_o(spi_miso_o),
  .spi_miso_oe_b(spi_miso_oe_b), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .isp_mode(isp_mode), .prog_enabled(prog_enabled));

// ### dv/ispp_prog_model.sv
// ispp_prog_model: behavioural programmer, master of the serial link.
// assumes the bench resolves miso and calls xfer one frame at a time.
`timescale 1ns/100ps
module ispp_prog_model #(
  // link logic has no tie to core_clk, so the bench runs sck slower on purpose
  parameter real HALF_NS = 24.0
) (
  // serial link
  output logic      sck,
  output logic      ss_b,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    ss_b = 1'b0;
    mosi = 1'b0;
    // a real rise of select clears the frame flops before the first frame
    #1 ss_b = 1'b1;
  end
  // clock runs only inside a frame; trailing part bits test realignment
  task automatic xfer(input logic [7:0] tx[$], input int part, output logic [7:0] rx[$]);
    int         nb;
    logic [7:0] sh;
    nb = tx.size() * 8 + part;
    rx = {};
    sh = 8'h00;
    ss_b = 1'b0;
    for (int i = 0; i < nb; i++) begin
      mosi = (i < tx.size() * 8) ? tx[i / 8][7 - i % 8] : i[0];
      #(HALF_NS) sck = 1'b1;
      sh = {sh[6:0], miso};
      if (i % 8 == 7) rx.push_back(sh);
      #(HALF_NS) sck = 1'b0;
    end
    #(HALF_NS) ss_b = 1'b1;
    mosi = ~mosi;
  endtask : xfer
endmodule : ispp_prog_model

// ### dv/test_isp_serial_program_port.sv
// test_isp_serial_program_port: self-checking bench for the serial programming port.
// assumes ispp_prog_model masters the link; received bytes are checked off a queue.
`timescale 1ns/100ps
module test_isp_serial_program_port;
  localparam int WR_N = 40;
  logic       core_clk, rst_b, sck, ss_b, mosi, miso_o, miso_oe_b, miso_w, hold_rx, en_exp;
  logic       rx_valid, rx_ready, tx_valid, tx_poll, tx_ready, isp_mode, prog_busy;
  logic       erase_busy, cyc_wr, cyc_awr, cyc_ers, prog_en, overrun, early;
  logic [7:0] rx_data, tx_data, d, e;
  logic [7:0] exp_q[$], q[$], r[$];
  int         n_errors, n_tests;
  always #12.5 core_clk = ~core_clk;
  // released line shows the inverse of the last level
  assign miso_w = miso_oe_b ? ~miso_o : miso_o;
  ispp_prog_model u_prog (.sck(sck), .ss_b(ss_b), .mosi(mosi), .miso(miso_w));
  ispp_port #(.WR_CYC(WR_N), .AWR_CYC(2 * WR_N), .ERS_CYC(3 * WR_N)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .spi_sck(sck), .spi_ss_b(ss_b), .spi_mosi(mosi),
    .spi_miso_o(miso_o), .spi_miso_oe_b(miso_oe_b), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_poll(tx_poll),
    .tx_ready(tx_ready), .isp_mode(isp_mode), .prog_busy(prog_busy), .erase_busy(erase_busy),
    .cyc_wr(cyc_wr), .cyc_awr(cyc_awr), .cyc_ers(cyc_ers), .prog_enabled(prog_en),
    .rx_overrun(overrun), .early_cmd(early));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic frame(input logic [7:0] b[$], input int part);
    if (en_exp) exp_q = {exp_q, b};
    #3 u_prog.xfer(b, part, r);
  endtask : frame

  task automatic session(input logic [7:0] first);
    @(posedge core_clk);
    isp_mode <= 1'b0;
    repeat (3) @(posedge core_clk);
    isp_mode <= 1'b1;
    en_exp = 1'b0;
    frame({first}, 0);
    en_exp = (first === ispp_pkg::PROG_EN_OP);
    repeat (20) @(posedge core_clk);
    check(prog_en, en_exp);
  endtask : session

  task automatic put_tx(input logic [7:0] v, input logic poll);
    int k;
    k = 0;
    @(posedge core_clk);
    while (tx_ready !== 1'b1 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 400) n_errors++;
    tx_data <= v;
    tx_poll <= poll;
    tx_valid <= 1'b1;
    @(posedge core_clk);
    tx_valid <= 1'b0;
    #1 check(tx_ready, 1'b0);
  endtask : put_tx

  // random stalls on the drain side, or a full stop while the buffer fills
  always @(posedge core_clk) rx_ready <= hold_rx ? 1'b0 : 1'($urandom % 2);

  always @(posedge core_clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0) check(rx_data, 8'hxx);
      else check(rx_data, exp_q.pop_front());
    end
  end

  initial begin
    // reset starts high so that its fall is a true edge for the link-side flops
    {core_clk, rst_b, tx_valid, tx_poll, isp_mode, prog_busy, erase_busy} = 7'h20;
    {cyc_wr, cyc_awr, cyc_ers, hold_rx, en_exp, rx_ready} = 6'h0;
    tx_data = 8'h00;
    n_errors = 0;
    n_tests = 0;
    void'($urandom(32'haf78));
    #1 rst_b = 1'b0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    session(~ispp_pkg::PROG_EN_OP);
    frame({8'h11, 8'h22}, 0);
    session(ispp_pkg::PROG_EN_OP);
    frame({8'h3c}, 5);
    frame({8'hc3, 8'h96}, 0);
    for (int m = 0; m < 4; m++) begin
      d = 8'($urandom);
      @(posedge core_clk);
      prog_busy <= (m < 2);
      erase_busy <= (m == 2);
      put_tx(d, m != 0);
      e = (m == 2) ? ispp_pkg::POLL_ERASE : (m == 1) ? d ^ ispp_pkg::POLL_MSB : d;
      frame({8'($urandom), 8'($urandom)}, 0);
      check(r[1], e);
    end
    @(posedge core_clk);
    {prog_busy, erase_busy} <= 2'h0;
    for (int k = 0; k < 6; k++) begin
      repeat (130) @(posedge core_clk);
      session(ispp_pkg::PROG_EN_OP);
      @(posedge core_clk);
      {cyc_wr, cyc_awr, cyc_ers} <= 3'h1 << (k % 3);
      @(posedge core_clk);
      {cyc_wr, cyc_awr, cyc_ers} <= 3'h0;
      if (k > 2) repeat ((3 - k % 3) * WR_N + 10) @(posedge core_clk);
      frame({8'($urandom)}, 0);
      repeat (20) @(posedge core_clk);
      check(early, k < 3);
    end
    hold_rx <= 1'b1;
    repeat (20) @(posedge core_clk);
    q = {};
    repeat (20) q.push_back(8'($urandom));
    frame(q, 0);
    repeat (30) @(posedge core_clk);
    check(overrun, 1'b1);
    hold_rx <= 1'b0;
    repeat (300) @(posedge core_clk);
    check(rx_valid, 1'b0);
    exp_q.delete();
    print_verdict();
  end

  initial begin
    #1_000_000;
    n_errors++;
    print_verdict();
  end
endmodule : test_isp_serial_program_port
